// *** core/tws_defines.svh ***
// Constants of the two-wire master that drives the pointer-port sensor
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TWS_CLK_HZ 10000000
`define TWS_SCL_HZ 100000

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define TWS_ADDR_BASE 4'h8
`define TWS_RW_WRITE 1'b0
`define TWS_RW_READ 1'b1
`define TWS_GC_ADDR 8'h00
`define TWS_GC_RESET 8'h06

// ----------------------------------------------------------------------
// Data path
// ----------------------------------------------------------------------
`define TWS_WORD_W 16
`define TWS_FIFO_DEPTH 16

`endif

// *** core/tws_pkg.sv ***
// Types of the two-wire master
package tws_pkg;

    typedef enum logic [2:0] {
        OP_WR = 3'b000,
        OP_PTR = 3'b001,
        OP_RD = 3'b010,
        OP_PTRRD = 3'b011,
        OP_GCRST = 3'b100
    } tws_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_BYTE = 3'b010,
        S_RSTART = 3'b011,
        S_STOP = 3'b100
    } tws_state_t;

    typedef enum logic [2:0] {
        K_TX = 3'b000,
        K_RX = 3'b001,
        K_RXL = 3'b010,
        K_RS = 3'b011,
        K_STOP = 3'b100
    } tws_kind_t;

    typedef struct packed {
        tws_op_t op;
        logic [2:0] sel;
        logic [7:0] ptr;
        logic [15:0] wdata;
    } tws_cmd_t;

endpackage

// *** core/tws_master.sv ***
// Two-wire bus master for the pointer-port sensor, with read-data FIFO
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"

// ----------------------------------------------------------------------
// Read-data FIFO with registered output stage
// ----------------------------------------------------------------------
module tws_fifo
    import tws_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 16
)(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] cnt_ff;
    logic ov_ff;
    logic [W-1:0] od_ff;
    wire push = in_valid_i && in_ready_o;
    wire pop = (cnt_ff != '0) && (!ov_ff || out_ready_i);

    assign in_ready_o = (cnt_ff < (AW+1)'(D));
    assign out_valid_o = ov_ff;
    assign out_data_o = od_ff;

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem[wptr_ff] <= in_data_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
            ov_ff <= 1'b0;
            od_ff <= '0;
        end
        else
        begin
            if (push)
                wptr_ff <= wptr_ff + AW'(1);
            if (pop)
            begin
                rptr_ff <= rptr_ff + AW'(1);
                od_ff <= mem[rptr_ff];
                ov_ff <= 1'b1;
            end
            else if (out_ready_i)
                ov_ff <= 1'b0;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------
// Bus master
// ----------------------------------------------------------------------
// How it works
// - Clock rate between 1 kHz and 2.5 MHz
// - Every byte shifted most significant bit first
// - This master makes clock, start and stop
// - Start: data falls while clock high
// - Address byte: seven bits then direction
// - Eight data clocks then one acknowledge
// - Data stable while clock high
// - Stop: data rises while clock high
// - First byte after write address: pointer
// - Pointer change: address, pointer, restart, read
// - Master ends read with not-acknowledge
module tws_master
    import tws_pkg::*;
#(
    parameter int CLK_HZ = `TWS_CLK_HZ,
    parameter int SCL_HZ = `TWS_SCL_HZ,
    parameter int FIFO_DEPTH = `TWS_FIFO_DEPTH
)(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire tws_cmd_t cmd_i,
    output logic cmd_ready_o,
    // Read data stream
    output logic rd_valid_o,
    output logic [`TWS_WORD_W-1:0] rd_data_o,
    input wire logic rd_ready_i,
    // Status
    output logic done_o,
    output logic nack_o,
    // Bus pins
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    // Quarter of a clock period, rounded up so the rate never runs fast
    localparam int QTR = ((CLK_HZ + 4*SCL_HZ - 1) / (4*SCL_HZ) < 1) ? 1 :
        (CLK_HZ + 4*SCL_HZ - 1) / (4*SCL_HZ);
    localparam logic [15:0] QTR_M1 = 16'(QTR - 1);

    tws_state_t st_ff;
    tws_cmd_t cmd_ff;
    logic [15:0] cnt_ff;
    logic [1:0] q_ff;
    logic [3:0] bit_ff;
    logic [2:0] step_ff;
    logic [7:0] txb_ff;
    logic [15:0] rxsh_ff;
    logic ack_ff;
    logic scl_oe_ff;
    logic sda_oe_ff;
    logic zero_ff;
    logic cmd_ready_ff;
    logic done_ff;
    logic nack_ff;
    logic push_ff;
    logic sda_m_ff;
    logic sda_s_ff;
    logic fifo_in_rdy;

    // ------------------------------------------------------------------
    // Transaction scripts
    // ------------------------------------------------------------------
    function automatic tws_kind_t step_kind(tws_op_t op, logic [2:0] s);
        tws_kind_t k;
        k = K_STOP;
        unique case (op)
            OP_WR: k = (s < 3'h4) ? K_TX : K_STOP;
            OP_PTR, OP_GCRST: k = (s < 3'h2) ? K_TX : K_STOP;
            OP_RD: k = (s == 3'h0) ? K_TX : (s == 3'h1) ? K_RX :
                (s == 3'h2) ? K_RXL : K_STOP;
            OP_PTRRD: k = (s < 3'h2) ? K_TX : (s == 3'h2) ? K_RS :
                (s == 3'h3) ? K_TX : (s == 3'h4) ? K_RX :
                (s == 3'h5) ? K_RXL : K_STOP;
            default: k = K_STOP;
        endcase
        return k;
    endfunction

    function automatic logic [7:0] tx_byte(tws_cmd_t c, logic [2:0] s);
        logic [7:0] aw;
        logic [7:0] ar;
        logic [7:0] b;
        aw = {`TWS_ADDR_BASE, c.sel, `TWS_RW_WRITE};
        ar = {`TWS_ADDR_BASE, c.sel, `TWS_RW_READ};
        b = aw;
        unique case (c.op)
            OP_GCRST: b = (s == 3'h0) ? `TWS_GC_ADDR : `TWS_GC_RESET;
            OP_RD: b = ar;
            OP_PTRRD: b = (s == 3'h1) ? c.ptr : (s == 3'h3) ? ar : aw;
            OP_WR: b = (s == 3'h1) ? c.ptr : (s == 3'h2) ? c.wdata[15:8] :
                (s == 3'h3) ? c.wdata[7:0] : aw;
            OP_PTR: b = (s == 3'h1) ? c.ptr : aw;
            default: b = aw;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire qtick = (st_ff != S_IDLE) && (cnt_ff == QTR_M1);
    wire take = cmd_valid_i && cmd_ready_ff;
    wire tws_kind_t cur_kind = step_kind(cmd_ff.op, step_ff);
    wire is_tx = (cur_kind == K_TX);
    wire last_bit = (bit_ff == 4'h8);
    wire byte_end = (st_ff == S_BYTE) && qtick && (q_ff == 2'h3) && last_bit;
    wire nacked = byte_end && is_tx && ack_ff;
    wire enter = qtick && (((st_ff == S_START) && (q_ff == 2'h1)) ||
        (byte_end && !nacked) || ((st_ff == S_RSTART) && (q_ff == 2'h3)));
    wire [2:0] nxt_step = (st_ff == S_START) ? step_ff : step_ff + 3'h1;
    wire tws_kind_t nxt_kind = step_kind(cmd_ff.op, nxt_step);
    wire [7:0] nxt_txb = tx_byte(cmd_ff, nxt_step);
    wire tws_state_t enter_st = (nxt_kind == K_RS) ? S_RSTART :
        (nxt_kind == K_STOP) ? S_STOP : S_BYTE;
    // MSB first; ack slot released on send, not-ack on last read byte
    wire drv_bit = !last_bit ? (!is_tx || txb_ff[3'(4'h7 - bit_ff)]) :
        (is_tx || (cur_kind == K_RXL));

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        sda_m_ff <= sda_i;
        sda_s_ff <= sda_m_ff;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            st_ff <= S_IDLE;
            cmd_ff <= '0;
            cnt_ff <= 16'h0;
            q_ff <= 2'h0;
            bit_ff <= 4'h0;
            step_ff <= 3'h0;
            txb_ff <= 8'h0;
            rxsh_ff <= 16'h0;
            ack_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            zero_ff <= 1'b0;
            cmd_ready_ff <= 1'b0;
            done_ff <= 1'b0;
            nack_ff <= 1'b0;
            push_ff <= 1'b0;
        end
        else
        begin
            zero_ff <= 1'b0;
            done_ff <= 1'b0;
            push_ff <= byte_end && (cur_kind == K_RXL);
            cmd_ready_ff <= (st_ff == S_IDLE) && !take && fifo_in_rdy;
            cnt_ff <= (st_ff == S_IDLE || qtick) ? 16'h0 : cnt_ff + 16'h1;
            if (qtick)
                q_ff <= q_ff + 2'h1;
            unique case (st_ff)
                S_IDLE:
                    if (take)
                    begin
                        cmd_ff <= cmd_i;
                        step_ff <= 3'h0;
                        q_ff <= 2'h0;
                        nack_ff <= 1'b0;
                        st_ff <= S_START;
                    end
                S_START:
                    if (qtick && q_ff == 2'h0)
                        sda_oe_ff <= 1'b1;
                    else if (qtick && q_ff == 2'h1)
                        scl_oe_ff <= 1'b1;
                S_BYTE:
                    if (qtick)
                    begin
                        unique case (q_ff)
                            2'h0: sda_oe_ff <= !drv_bit;
                            2'h1: scl_oe_ff <= 1'b0;
                            2'h2:
                                if (!last_bit && !is_tx)
                                    rxsh_ff <= {rxsh_ff[14:0], sda_s_ff};
                                else if (last_bit)
                                    ack_ff <= sda_s_ff;
                            2'h3:
                            begin
                                scl_oe_ff <= 1'b1;
                                bit_ff <= bit_ff + 4'h1;
                                if (nacked)
                                begin
                                    nack_ff <= 1'b1;
                                    st_ff <= S_STOP;
                                end
                            end
                        endcase
                    end
                S_RSTART:
                    if (qtick)
                    begin
                        unique case (q_ff)
                            2'h0: sda_oe_ff <= 1'b0;
                            2'h1: scl_oe_ff <= 1'b0;
                            2'h2: sda_oe_ff <= 1'b1;
                            2'h3: scl_oe_ff <= 1'b1;
                        endcase
                    end
                S_STOP:
                    if (qtick)
                    begin
                        unique case (q_ff)
                            2'h0: sda_oe_ff <= 1'b1;
                            2'h1: scl_oe_ff <= 1'b0;
                            2'h2: sda_oe_ff <= 1'b0;
                            2'h3:
                            begin
                                st_ff <= S_IDLE;
                                done_ff <= 1'b1;
                            end
                        endcase
                    end
                default: st_ff <= S_IDLE;
            endcase
            if (enter)
            begin
                step_ff <= nxt_step;
                txb_ff <= nxt_txb;
                bit_ff <= 4'h0;
                q_ff <= 2'h0;
                st_ff <= enter_st;
            end
        end
    end

    tws_fifo #(
        .W(`TWS_WORD_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .in_valid_i(push_ff),
        .in_data_i(rxsh_ff),
        .in_ready_o(fifo_in_rdy),
        .out_valid_o(rd_valid_o),
        .out_data_o(rd_data_o),
        .out_ready_i(rd_ready_i)
    );

    assign cmd_ready_o = cmd_ready_ff;
    assign done_o = done_ff;
    assign nack_o = nack_ff;
    assign scl_o = zero_ff;
    assign scl_oe_o = scl_oe_ff;
    assign sda_o = zero_ff;
    assign sda_oe_o = sda_oe_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [15:0] scl_run_ff;
    logic [5:0] bticks_ff;
    wire scl_hi = !scl_oe_ff;
    wire sda_hi = !sda_oe_ff;

    always_ff @(posedge clk_sys_i)
    begin
        scl_run_ff <= $changed(scl_oe_ff) ? 16'h0 : scl_run_ff + 16'h1;
        bticks_ff <= (st_ff != S_BYTE || byte_end) ? 6'h0 :
            (qtick ? bticks_ff + 6'h1 : bticks_ff);
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_scl_min_half: assert property ($changed(scl_oe_ff) &&
        $past(scl_oe_ff) |-> 32'($past(scl_run_ff)) + 1 >= QTR)
        else $error("clock low phase too short");
    a_scl_max_low: assert property (!scl_hi && $past(!scl_hi)
        |-> 32'(scl_run_ff) < 3*QTR)
        else $error("clock held low too long");
    a_msb_first: assert property (st_ff == S_BYTE && is_tx &&
        !last_bit && scl_hi |-> sda_hi == txb_ff[3'(4'h7 - bit_ff)])
        else $error("sent bit out of order");
    a_start_cond: assert property ($fell(sda_hi) && scl_hi &&
        $past(scl_hi) |-> st_ff inside {S_START, S_RSTART})
        else $error("data fell with clock high outside start");
    a_addr_dir: assert property (st_ff == S_BYTE && step_ff == 3'h0 &&
        cmd_ff.op != OP_GCRST |-> txb_ff[0] == (cmd_ff.op == OP_RD))
        else $error("wrong direction bit");
    a_byte_slots: assert property (byte_end |-> bticks_ff == 6'h23)
        else $error("byte not nine clock slots");
    a_sda_stable: assert property (st_ff == S_BYTE &&
        $past(st_ff) == S_BYTE && scl_hi && $past(scl_hi)
        |-> $stable(sda_hi))
        else $error("data moved while clock high");
    a_stop_cond: assert property ($rose(sda_hi) && scl_hi &&
        $past(scl_hi) |-> st_ff == S_STOP ##[1:300] st_ff == S_IDLE)
        else $error("stop edge misplaced");
    a_ptr_first: assert property (st_ff == S_BYTE &&
        step_ff == 3'h1 && cmd_ff.op inside {OP_WR, OP_PTR, OP_PTRRD}
        |-> txb_ff == cmd_ff.ptr)
        else $error("pointer not first after write address");
    a_restart_path: assert property (st_ff == S_RSTART
        |-> cmd_ff.op == OP_PTRRD && step_ff == 3'h2)
        else $error("restart without pointer write");
    a_last_nack: assert property (st_ff == S_BYTE &&
        cur_kind == K_RXL && last_bit && scl_hi |-> sda_hi)
        else $error("last read byte acknowledged");

    c_write_done: cover property (done_ff && cmd_ff.op == OP_WR && !nack_ff);
    c_ptr_read: cover property (push_ff && cmd_ff.op == OP_PTRRD);
    c_nacked: cover property (done_ff && nack_ff);
    c_fifo_full: cover property (!fifo_in_rdy);
endmodule

`default_nettype wire

// *** tb/tws_sensor_model.sv ***
// Behavioural pointer-port sensor model on the two-wire bus
`timescale 1ns/1ps
`default_nettype none

// ------------
// Sensor model
// ------------
module tws_sensor_model #(
    parameter logic [2:0] SEL = 3'h5,
    parameter logic [15:0] PU_BASE = 16'h1a00,
    // Bus timeout in ns, 30 ms
    parameter int TOUT_NS = 32'h01c9c380
)(
    // Bus wires
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o
);
    logic [15:0] regs [0:3];
    logic [7:0] ptr;
    logic [7:0] sh;
    logic [7:0] hi;
    logic [15:0] word;
    logic act = 1'b0;
    logic tx = 1'b0;
    logic gc = 1'b0;
    int bitn = 0;
    int byten = 0;
    realtime low_since = 0.0;

    task automatic power_up();
        for (int i = 0; i < 4; i++)
            regs[i] = PU_BASE + 16'(i);
        ptr = 8'h00;
    endtask

    task automatic take_byte();
        if (byten == 0)
        begin
            gc = (sh == 8'h00);
            if (sh[7:1] == {4'h8, SEL} || gc)
            begin
                sda_oe_o = 1'b1;
                tx = sh[0];
                word = regs[ptr[1:0]];
            end
            else
                act = 1'b0;
        end
        else
        begin
            sda_oe_o = 1'b1;
            if (gc)
            begin
                if (byten == 1 && sh == 8'h06)
                    power_up();
            end
            else if (byten == 1)
                ptr = sh;
            else if (byten == 2)
                hi = sh;
            else if (byten == 3)
                regs[ptr[1:0]] = {hi, sh};
        end
    endtask

    initial
    begin
        sda_oe_o = 1'b0;
        power_up();
    end

    // Start restarts the byte count
    always @(negedge sda_i)
    begin
        if (scl_i === 1'b1)
        begin
            act = 1'b1;
            tx = 1'b0;
            gc = 1'b0;
            bitn = 0;
            byten = 0;
            sda_oe_o = 1'b0;
        end
    end

    always @(posedge sda_i)
    begin
        if (scl_i === 1'b1)
        begin
            act = 1'b0;
            sda_oe_o = 1'b0;
        end
    end

    always @(posedge scl_i)
    begin
        if (act)
        begin
            if (bitn < 8)
                sh = {sh[6:0], sda_i};
            else if (tx && byten > 0 && sda_i)
                act = 1'b0;
            bitn = (bitn == 8) ? 0 : bitn + 1;
            if (bitn == 0)
                byten++;
        end
    end

    // Released line shows the pull-up
    always @(negedge scl_i)
    begin
        sda_oe_o = 1'b0;
        if (act && bitn == 8 && !tx)
            take_byte();
        else if (act && tx && bitn < 8 && byten > 0 && byten < 3)
            sda_oe_o = ~word[(byten == 1 ? 15 : 7) - bitn];
    end

    // Long clock low frees the bus
    always @(negedge scl_i)
        low_since = $realtime;

    always #1000
    begin
        if (act && scl_i === 1'b0 && $realtime - low_since >= TOUT_NS)
        begin
            act = 1'b0;
            sda_oe_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the two-wire master against a sensor model
`timescale 1ns/1ps
`default_nettype none

// ----------
// Testbench
// ----------
module testbench
    import tws_pkg::*;
;
    localparam logic [2:0] SEL = 3'h5;
    localparam logic [15:0] PU_BASE = 16'h1a00;
    localparam int LIMIT = 60000;
    logic clk_sys_i = 1'b0;
    logic srst_i;
    logic cmd_valid_i;
    tws_cmd_t cmd_i;
    logic cmd_ready_o;
    logic rd_valid_o;
    logic [15:0] rd_data_o;
    logic rd_ready_i = 1'b0;
    logic done_o;
    logic nack_o;
    logic scl_oe_o;
    logic sda_oe_o;
    logic scl_o;
    logic sda_o;
    logic slv_oe;
    logic scl_w;
    logic sda_w;
    logic hold_rd = 1'b0;
    logic [31:0] lfsr_st = 32'h8e75564e;
    logic [15:0] exp_regs [0:3];
    logic [1:0] exp_ptr;
    logic [15:0] rd_q [$];
    int n_errors = 0;
    int checks_done = 0;
    int n_start = 0;
    int n_stop = 0;
    int cycles = 0;

    // Open-drain wires with pull-ups; the master drives its out level
    assign scl_w = scl_oe_o ? scl_o : 1'b1;
    assign sda_w = slv_oe ? 1'b0 : (sda_oe_o ? sda_o : 1'b1);

    tws_master #(
        .CLK_HZ(10000000),
        .SCL_HZ(1000000),
        .FIFO_DEPTH(16)
    ) DUT (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i),
        .cmd_ready_o(cmd_ready_o),
        .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o),
        .rd_ready_i(rd_ready_i),
        .done_o(done_o),
        .nack_o(nack_o),
        .scl_o(scl_o),
        .scl_oe_o(scl_oe_o),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );

    tws_sensor_model #(
        .SEL(SEL),
        .PU_BASE(PU_BASE)
    ) SLV (
        .scl_i(scl_w),
        .sda_i(sda_w),
        .sda_oe_o(slv_oe)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic reset_model();
        for (int i = 0; i < 4; i++)
            exp_regs[i] = PU_BASE + 16'(i);
        exp_ptr = 2'h0;
    endtask

    // One bus command, offered at a rising edge
    task automatic do_cmd(input tws_op_t op, input logic [2:0] sel,
                          input logic [7:0] ptr);
        int n;
        int s0;
        int p0;
        logic nk;
        logic [15:0] wd;
        nk = (op != OP_GCRST) && (sel != SEL);
        wd = lfsr_st[15:0];
        cmd_i <= '{op: op, sel: sel, ptr: ptr, wdata: wd};
        cmd_valid_i <= 1'b1;
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end
        while (cmd_ready_o !== 1'b1 && n < 4000);
        @(posedge clk_sys_i);
        cmd_valid_i <= 1'b0;
        s0 = n_start;
        p0 = n_stop;
        if (!nk && op inside {OP_WR, OP_PTR, OP_PTRRD})
            exp_ptr = ptr[1:0];
        if (!nk && op == OP_WR)
            exp_regs[exp_ptr] = wd;
        if (!nk && op inside {OP_RD, OP_PTRRD})
            rd_q.push_back(exp_regs[exp_ptr]);
        if (op == OP_GCRST)
            reset_model();
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end
        while (done_o !== 1'b1 && n < 4000);
        check("done", n < 4000, 1'b1);
        check("nack", nack_o, nk);
        check("starts", n_start - s0, (op == OP_PTRRD) ? 2 : 1);
        check("stops", n_stop - p0, 1);
        check("idle", {scl_w, sda_w}, 2'b11);
        check("drive level", {scl_o, sda_o}, 2'b00);
        @(posedge clk_sys_i);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (rd_q.size() != 0 && n < 8000)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        check("words left", rd_q.size(), 0);
    endtask

    initial
    begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    always @(negedge sda_w)
        if (scl_w === 1'b1)
            n_start++;

    always @(posedge sda_w)
        if (scl_w === 1'b1)
            n_stop++;

    always @(posedge clk_sys_i)
    begin
        lfsr_st <= lfsr_next(lfsr_st);
        rd_ready_i <= !hold_rd && lfsr_st[7];
        cycles++;
        if (cycles == LIMIT)
        begin
            n_errors++;
            print_verdict();
        end
    end

    // Word is taken at the next rising edge
    always @(negedge clk_sys_i)
    begin
        if (rd_valid_o === 1'b1 && rd_ready_i)
        begin
            if (rd_q.size() == 0)
                check("word unexpected", 1'b1, 1'b0);
            else
                check("read word", rd_data_o, rd_q.pop_front());
        end
    end

    initial
    begin
        int n;
        srst_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_i = '0;
        reset_model();
        repeat (16) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        for (int s = 0; s < 8; s++)
            do_cmd(OP_WR, 3'(s), 8'h00);
        for (int p = 1; p < 4; p++)
            do_cmd(OP_WR, SEL, 8'(p));
        for (int p = 0; p < 4; p++)
            do_cmd(OP_PTRRD, SEL, 8'(p));
        do_cmd(OP_RD, SEL, 8'h00);
        do_cmd(OP_RD, SEL, 8'h00);
        do_cmd(OP_PTR, SEL, 8'h01);
        do_cmd(OP_RD, SEL, 8'h00);
        do_cmd(OP_RD, SEL ^ 3'h2, 8'h00);
        do_cmd(OP_GCRST, 3'h0, 8'h00);
        for (int p = 0; p < 4; p++)
            do_cmd(OP_PTRRD, SEL, 8'(p));
        drain();
        hold_rd = 1'b1;
        for (int i = 0; i < 17; i++)
            do_cmd(OP_RD, SEL, 8'h00);
        n = 0;
        repeat (100)
        begin
            @(negedge clk_sys_i);
            n += (cmd_ready_o !== 1'b0);
        end
        check("ready while full", n, 0);
        hold_rd = 1'b0;
        do_cmd(OP_RD, SEL, 8'h00);
        drain();
        print_verdict();
    end
endmodule
`default_nettype wire
